// ### hw/link_regs.sv
// link width and link control register bank with axi4-lite slave
//
// Implementation choice: the AXI4-Lite slave port.
module link_regs (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic [11:0] I_S_AXI_AWADDR,
	input wire logic I_S_AXI_AWVALID,
	output logic O_S_AXI_AWREADY,
	input wire logic [31:0] I_S_AXI_WDATA,
	input wire logic [3:0] I_S_AXI_WSTRB,
	input wire logic I_S_AXI_WVALID,
	output logic O_S_AXI_WREADY,
	output logic [1:0] O_S_AXI_BRESP,
	output logic O_S_AXI_BVALID,
	input wire logic I_S_AXI_BREADY,
	input wire logic [11:0] I_S_AXI_ARADDR,
	input wire logic I_S_AXI_ARVALID,
	output logic O_S_AXI_ARREADY,
	output logic [31:0] O_S_AXI_RDATA,
	output logic [1:0] O_S_AXI_RRESP,
	output logic O_S_AXI_RVALID,
	input wire logic I_S_AXI_RREADY,
	input wire logic [1:0] I_MODE,
	input wire logic I_WARM_RST_B,
	input wire logic I_LINK_CLK,
	input wire logic I_STOP_B,
	input wire logic I_NEG_DONE,
	input wire logic [2:0] I_NEG_WIDTH,
	input wire logic I_EOC_DROP,
	input wire logic I_OVERFLOW,
	input wire logic I_LINK_REQ_VALID,
	input wire logic [63:0] I_LINK_REQ_ADDR,
	input wire logic I_LINK_REQ_EXT,
	input wire logic I_BUS_REQ_VALID,
	input wire logic [63:0] I_BUS_REQ_ADDR,
	output logic O_LINK_REQ_ACCEPT,
	output logic O_LINK_REQ_ABORT,
	output logic O_BUS_REQ_FWD,
	output logic O_BUS_REQ_EXT,
	output logic O_BUS_REQ_ABORT,
	output logic [2:0] O_ACTIVE_WIDTH,
	output logic O_CTL,
	output logic O_TX_OE,
	output logic O_SECOND_SPACE_VISIBLE,
	output logic O_IRQ
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic awready;
		logic aw_busy;
		logic [11:0] aw_addr;
		logic wready;
		logic w_busy;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic warm_s1;
		logic warm_s2;
		logic stop_s1;
		logic stop_s2;
		logic stop_prev;
		logic lclk_s1;
		logic lclk_s2;
		logic lclk_prev;
		logic negd_s1;
		logic negd_s2;
		logic [2:0] negw_s1;
		logic [2:0] negw_s2;
		logic [2:0] width_in;
		logic [2:0] active_width;
		logic width_loaded;
		logic addr64_en;
		logic nxa_flag;
		logic ovf_flag;
		logic ext_ctl;
		logic tristate_en;
		logic [link_regs_pkg::CTL_CNT_W-1:0] ctl_cnt;
		logic ctl_out;
		logic tx_oe;
		logic second_vis;
		logic [link_regs_pkg::IRQ_W-1:0] irq_status;
		logic [link_regs_pkg::IRQ_W-1:0] irq_mask;
		logic irq;
		logic link_acc;
		logic link_abort;
		logic bus_fwd;
		logic bus_ext;
		logic bus_abort;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_generic(input link_regs_pkg::mode_t m);
		return (m == link_regs_pkg::GENERIC_SINGLE_MODE) || (m == link_regs_pkg::GENERIC_DUAL_MODE);
	endfunction

	function automatic logic above_limit(input logic [63:0] a);
		return |a[63:link_regs_pkg::ADDR_LIMIT_BITS];
	endfunction

	// bridge modes only carry 8 bits, generic adds 2 and 4
	function automatic logic width_ok(input link_regs_pkg::mode_t m, input logic [2:0] w);
		return (w == link_regs_pkg::WIDTH_8) ||
			(is_generic(m) && ((w == link_regs_pkg::WIDTH_2) || (w == link_regs_pkg::WIDTH_4)));
	endfunction

	function automatic logic [31:0] strb_mask(input logic [3:0] st);
		return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
	endfunction

	link_regs_pkg::mode_t md;
	logic gen;
	logic sb;
	logic dual;
	logic lclk_rise;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [11:0] widx;
	logic [11:0] ridx;
	logic [15:0] ctrl_rd;

	always_comb begin
		md = link_regs_pkg::mode_t'(s_reg.mode_s2);
		gen = is_generic(md);
		sb = (md == link_regs_pkg::SINGLE_BRIDGE_MODE);
		dual = (md == link_regs_pkg::DUAL_BRIDGE_MODE) || (md == link_regs_pkg::GENERIC_DUAL_MODE);
		lclk_rise = s_reg.lclk_s2 && !s_reg.lclk_prev;
		wmask = strb_mask(s_reg.wstrb);
		wval = s_reg.wdata & wmask;
		widx = {2'h0, s_reg.aw_addr[11:2]};
		ridx = {2'h0, I_S_AXI_ARADDR[11:2]};
		// link 1 control is hidden in dual modes
		if (dual) begin
			ctrl_rd = 16'h0000;
		end else if (sb) begin
			ctrl_rd = {1'b0, s_reg.nxa_flag, s_reg.ovf_flag, 13'h0000};
		end else begin
			ctrl_rd = {s_reg.addr64_en, s_reg.ext_ctl, s_reg.tristate_en, 13'h0000};
		end

		s_next = s_reg;

		// ****************************************
		// synchronisers
		// ****************************************
		s_next.mode_s1 = I_MODE;
		s_next.mode_s2 = s_reg.mode_s1;
		s_next.warm_s1 = I_WARM_RST_B;
		s_next.warm_s2 = s_reg.warm_s1;
		s_next.stop_s1 = I_STOP_B;
		s_next.stop_s2 = s_reg.stop_s1;
		s_next.stop_prev = s_reg.stop_s2;
		s_next.lclk_s1 = I_LINK_CLK;
		s_next.lclk_s2 = s_reg.lclk_s1;
		s_next.lclk_prev = s_reg.lclk_s2;
		s_next.negd_s1 = I_NEG_DONE;
		s_next.negd_s2 = s_reg.negd_s1;
		s_next.negw_s1 = I_NEG_WIDTH;
		s_next.negw_s2 = s_reg.negw_s1;
		s_next.second_vis = dual;

		// ****************************************
		// axi write
		// ****************************************
		if (s_reg.bvalid && I_S_AXI_BREADY) begin
			s_next.bvalid = 1'b0;
		end
		if (I_S_AXI_AWVALID && s_reg.awready) begin
			s_next.aw_busy = 1'b1;
			s_next.aw_addr = I_S_AXI_AWADDR;
		end
		if (I_S_AXI_WVALID && s_reg.wready) begin
			s_next.w_busy = 1'b1;
			s_next.wdata = I_S_AXI_WDATA;
			s_next.wstrb = I_S_AXI_WSTRB;
		end
		if (s_reg.aw_busy && s_reg.w_busy && !s_reg.bvalid) begin
			s_next.aw_busy = 1'b0;
			s_next.w_busy = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = link_regs_pkg::RESP_OKAY;
			case (widx)
				link_regs_pkg::IDX_WIDTH_CFG: begin
					// bridge modes keep the field read-only; unsupported codes are dropped
					if (gen && s_reg.wstrb[1] && width_ok(md, wval[10:8])) begin
						s_next.width_in = wval[10:8];
					end
				end
				link_regs_pkg::IDX_LINK1_CTRL: begin
					if (sb) begin
						// write-one clears; zero leaves the flag alone
						if (wval[link_regs_pkg::BIT14]) begin
							s_next.nxa_flag = 1'b0;
						end
						if (wval[link_regs_pkg::BIT13]) begin
							s_next.ovf_flag = 1'b0;
						end
					end else if (gen && s_reg.wstrb[1]) begin
						s_next.addr64_en = s_reg.wdata[link_regs_pkg::ADDR64_BIT];
						s_next.ext_ctl = s_reg.wdata[link_regs_pkg::BIT14];
						s_next.tristate_en = s_reg.wdata[link_regs_pkg::BIT13];
					end
				end
				link_regs_pkg::IDX_IRQ_MASK: begin
					s_next.irq_mask = (s_reg.irq_mask & ~wmask[3:0]) | wval[3:0];
				end
				link_regs_pkg::IDX_IRQ_STATUS, link_regs_pkg::IDX_LINK_STATE: begin
					s_next.bresp = link_regs_pkg::RESP_OKAY;
				end
				default: begin
					s_next.bresp = link_regs_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_next.awready = !s_next.aw_busy && !s_next.bvalid;
		s_next.wready = !s_next.w_busy && !s_next.bvalid;

		// ****************************************
		// axi read
		// ****************************************
		if (s_reg.rvalid && I_S_AXI_RREADY) begin
			s_next.rvalid = 1'b0;
		end
		if (I_S_AXI_ARVALID && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = link_regs_pkg::RESP_OKAY;
			s_next.rdata = 32'h0000_0000;
			case (ridx)
				link_regs_pkg::IDX_WIDTH_CFG: begin
					// dword flow control bits 7 and 3 are unsupported and read 0
					s_next.rdata[10:8] = s_reg.width_in;
					s_next.rdata[7] = 1'b0;
					s_next.rdata[6:4] = link_regs_pkg::MAX_WIDTH_OUT;
					s_next.rdata[3] = 1'b0;
					s_next.rdata[2:0] = link_regs_pkg::MAX_WIDTH_IN;
				end
				link_regs_pkg::IDX_LINK1_CTRL: begin
					s_next.rdata[15:0] = ctrl_rd;
				end
				link_regs_pkg::IDX_IRQ_STATUS: begin
					s_next.rdata[3:0] = s_reg.irq_status;
					s_next.irq_status = 4'h0;
				end
				link_regs_pkg::IDX_IRQ_MASK: begin
					s_next.rdata[3:0] = s_reg.irq_mask;
				end
				link_regs_pkg::IDX_LINK_STATE: begin
					s_next.rdata[2:0] = s_reg.active_width;
					s_next.rdata[4:3] = s_reg.mode_s2;
					s_next.rdata[5] = s_reg.width_loaded;
				end
				default: begin
					s_next.rresp = link_regs_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_next.arready = !s_next.rvalid;

		// ****************************************
		// width load and warm reset
		// ****************************************
		if (!s_reg.width_loaded && s_reg.negd_s2) begin
			s_next.width_loaded = 1'b1;
			s_next.width_in = width_ok(md, s_reg.negw_s2) ? s_reg.negw_s2 : link_regs_pkg::WIDTH_8;
			s_next.active_width = s_next.width_in;
			s_next.irq_status[2] = 1'b1;
		end
		// software width only reaches the link through a warm reset
		if (!s_reg.warm_s2) begin
			s_next.active_width = s_reg.width_in;
			s_next.addr64_en = 1'b0;
			s_next.irq_status[3] = 1'b1;
		end

		// ****************************************
		// error flags, set after clears so set wins
		// ****************************************
		if (sb && I_EOC_DROP) begin
			s_next.nxa_flag = 1'b1;
			s_next.irq_status[0] = 1'b1;
		end
		if (sb && I_OVERFLOW) begin
			s_next.ovf_flag = 1'b1;
			s_next.irq_status[1] = 1'b1;
		end
		s_next.irq = |(s_next.irq_status & ~s_next.irq_mask);

		// ****************************************
		// address checks
		// ****************************************
		s_next.link_acc = 1'b0;
		s_next.link_abort = 1'b0;
		if (I_LINK_REQ_VALID) begin
			if (!above_limit(I_LINK_REQ_ADDR)) begin
				s_next.link_acc = 1'b1;
			end else if (gen && s_reg.addr64_en && I_LINK_REQ_EXT) begin
				s_next.link_acc = 1'b1;
			end else begin
				s_next.link_abort = 1'b1;
			end
		end
		s_next.bus_fwd = 1'b0;
		s_next.bus_ext = 1'b0;
		s_next.bus_abort = 1'b0;
		if (I_BUS_REQ_VALID) begin
			if (!above_limit(I_BUS_REQ_ADDR)) begin
				s_next.bus_fwd = 1'b1;
			end else if (s_reg.addr64_en) begin
				s_next.bus_fwd = 1'b1;
				s_next.bus_ext = 1'b1;
			end else begin
				s_next.bus_abort = 1'b1;
			end
		end

		// ****************************************
		// stop sequence and control line
		// ****************************************
		// count in core cycles: the link clock may be far slower and jittery
		if (s_reg.ctl_cnt != '0) begin
			s_next.ctl_cnt = s_reg.ctl_cnt - 1'b1;
		end
		if (s_reg.stop_s2 && !s_reg.stop_prev) begin
			if (gen && s_reg.ext_ctl) begin
				s_next.ctl_cnt = link_regs_pkg::CTL_CNT_W'(link_regs_pkg::CTL_EXT_CYC);
			end else begin
				s_next.ctl_cnt = link_regs_pkg::CTL_CNT_W'(link_regs_pkg::CTL_BASE_CYC);
			end
		end
		s_next.ctl_out = (s_next.ctl_cnt != '0);
		// drivers change only on a link clock edge
		if (lclk_rise) begin
			s_next.tx_oe = !(gen && s_reg.tristate_en && !s_reg.stop_s2);
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			s_reg <= '0;
			s_reg.warm_s1 <= 1'b1;
			s_reg.warm_s2 <= 1'b1;
			s_reg.stop_s1 <= 1'b1;
			s_reg.stop_s2 <= 1'b1;
			s_reg.stop_prev <= 1'b1;
			s_reg.tx_oe <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign O_S_AXI_AWREADY = s_reg.awready;
	assign O_S_AXI_WREADY = s_reg.wready;
	assign O_S_AXI_BRESP = s_reg.bresp;
	assign O_S_AXI_BVALID = s_reg.bvalid;
	assign O_S_AXI_ARREADY = s_reg.arready;
	assign O_S_AXI_RDATA = s_reg.rdata;
	assign O_S_AXI_RRESP = s_reg.rresp;
	assign O_S_AXI_RVALID = s_reg.rvalid;
	assign O_LINK_REQ_ACCEPT = s_reg.link_acc;
	assign O_LINK_REQ_ABORT = s_reg.link_abort;
	assign O_BUS_REQ_FWD = s_reg.bus_fwd;
	assign O_BUS_REQ_EXT = s_reg.bus_ext;
	assign O_BUS_REQ_ABORT = s_reg.bus_abort;
	assign O_ACTIVE_WIDTH = s_reg.active_width;
	assign O_CTL = s_reg.ctl_out;
	assign O_TX_OE = s_reg.tx_oe;
	assign O_SECOND_SPACE_VISIBLE = s_reg.second_vis;
	assign O_IRQ = s_reg.irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RST_B);

	property p_width_code;
		s_reg.width_in inside {3'h4, 3'h5, 3'h0, 3'h1, 3'h3};
	endproperty
	a_width_code: assert property (p_width_code) else $error("bad width code");

	property p_bridge_8bit;
		(!gen && $stable(s_reg.mode_s2) && $past(!gen)) |-> $stable(s_reg.width_in) || s_reg.width_in == 3'h0;
	endproperty
	a_bridge_8bit: assert property (p_bridge_8bit) else $error("bridge mode width changed");

	property p_active_hold;
		$changed(s_reg.active_width) |-> $past(!s_reg.warm_s2 || !s_reg.width_loaded);
	endproperty
	a_active_hold: assert property (p_active_hold) else $error("active width moved without reset");

	property p_warm_clear;
		!s_reg.warm_s2 |=> !s_reg.addr64_en;
	endproperty
	a_warm_clear: assert property (p_warm_clear) else $error("64-bit enable survived warm reset");

	property p_link_abort;
		(I_LINK_REQ_VALID && above_limit(I_LINK_REQ_ADDR) && !s_reg.addr64_en) |=> O_LINK_REQ_ABORT && !O_LINK_REQ_ACCEPT;
	endproperty
	a_link_abort: assert property (p_link_abort) else $error("high link request not aborted");

	property p_link_accept;
		(I_LINK_REQ_VALID && gen && s_reg.addr64_en && I_LINK_REQ_EXT) |=> O_LINK_REQ_ACCEPT;
	endproperty
	a_link_accept: assert property (p_link_accept) else $error("extended link request refused");

	property p_bus_ext;
		(I_BUS_REQ_VALID && above_limit(I_BUS_REQ_ADDR)) |=>
			(O_BUS_REQ_ABORT != (O_BUS_REQ_FWD && O_BUS_REQ_EXT)) && (O_BUS_REQ_ABORT == !$past(s_reg.addr64_en));
	endproperty
	a_bus_ext: assert property (p_bus_ext) else $error("high bus request mishandled");

	property p_nxa_set;
		(sb && I_EOC_DROP) |=> s_reg.nxa_flag && s_reg.irq_status[0];
	endproperty
	a_nxa_set: assert property (p_nxa_set) else $error("drop flag not set");

	property p_ovf_set;
		(sb && I_OVERFLOW) |=> s_reg.ovf_flag;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

	property p_ext_ctl;
		(s_reg.stop_s2 && !s_reg.stop_prev && gen && s_reg.ext_ctl) |=> O_CTL [*8] ##1 (s_reg.ctl_cnt > 12'h7c0);
	endproperty
	a_ext_ctl: assert property (p_ext_ctl) else $error("extended control time too short");

	property p_tristate;
		(lclk_rise && gen && s_reg.tristate_en && !s_reg.stop_s2) |=> !O_TX_OE;
	endproperty
	a_tristate: assert property (p_tristate) else $error("link driven during stop");

	property p_hidden;
		dual ##1 1'b1 |-> O_SECOND_SPACE_VISIBLE;
	endproperty
	a_hidden: assert property (p_hidden) else $error("second space not shown in dual mode");

	c_write: cover property (O_S_AXI_BVALID && I_S_AXI_BREADY);
	c_nxa_clear: cover property (s_reg.nxa_flag ##1 !s_reg.nxa_flag);
	c_ext_ctl: cover property ($rose(O_CTL) && s_reg.ext_ctl);
	c_irq: cover property ($rose(O_IRQ));

endmodule

// ### hw/link_regs_pkg.sv
// constants and types for the link width and link control register bank
package link_regs_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 12;
	// printed offsets are indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_WIDTH_CFG = 12'h046;
	localparam logic [ADDR_W-1:0] IDX_LINK1_CTRL = 12'h048;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h050;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h051;
	localparam logic [ADDR_W-1:0] IDX_LINK_STATE = 12'h052;

	// ****************************************
	// fields and values
	// ****************************************
	localparam int WIDTH_IN_LSB = 8;
	localparam int ADDR64_BIT = 15;
	localparam int BIT14 = 14;
	localparam int BIT13 = 13;
	localparam logic [2:0] WIDTH_2 = 3'h4;
	localparam logic [2:0] WIDTH_4 = 3'h5;
	localparam logic [2:0] WIDTH_8 = 3'h0;
	localparam logic [2:0] WIDTH_16 = 3'h1;
	localparam logic [2:0] WIDTH_32 = 3'h3;
	localparam logic [2:0] MAX_WIDTH_OUT = 3'h0;
	localparam logic [2:0] MAX_WIDTH_IN = 3'h0;
	localparam int ADDR_LIMIT_BITS = 40;
	localparam int IRQ_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// timing
	// ****************************************
	localparam int CORE_MHZ = 40;
	localparam int CTL_EXT_NS = 50000;
	localparam int CTL_BASE_NS = 1000;
	localparam int CTL_EXT_CYC = (CTL_EXT_NS * CORE_MHZ + 999) / 1000;
	localparam int CTL_BASE_CYC = (CTL_BASE_NS * CORE_MHZ + 999) / 1000;
	localparam int CTL_CNT_W = 12;

	typedef enum logic [1:0] {
		SINGLE_BRIDGE_MODE,
		DUAL_BRIDGE_MODE,
		GENERIC_SINGLE_MODE,
		GENERIC_DUAL_MODE
	} mode_t;

endpackage

// ### testbench/link_peer.sv
// peer link device model: link clock, stop signal and width negotiation result
module link_peer (
	input wire logic i_clk,
	output logic o_link_clk,
	output logic o_stop_b,
	output logic o_neg_done,
	output logic [2:0] o_neg_width
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// free running link clock, negotiated width held stable
	// ****************************************
	initial begin
		o_link_clk = 1'b0;
		o_stop_b = 1'b1;
		o_neg_done = 1'b1;
		o_neg_width = link_regs_pkg::WIDTH_4;
	end

	// link clock runs free, so no idle stretch is modelled
	always #100 o_link_clk = ~o_link_clk;

	task automatic drive_stop(input logic lvl);
		@(posedge i_clk);
		o_stop_b <= lvl;
	endtask
endmodule

// ### testbench/link_width_and_link_control_regs_test.sv
// self-checking bench for the link width and link control register bank
module link_width_and_link_control_regs_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// signals
	// ****************************************
	logic I_CORE_CLK, I_RST_B, I_S_AXI_AWVALID, I_S_AXI_WVALID, I_S_AXI_BREADY, I_S_AXI_ARVALID, I_S_AXI_RREADY;
	logic [11:0] I_S_AXI_AWADDR, I_S_AXI_ARADDR;
	logic [31:0] I_S_AXI_WDATA, O_S_AXI_RDATA, seed, rd;
	logic [3:0] I_S_AXI_WSTRB;
	logic [1:0] I_MODE, O_S_AXI_BRESP, O_S_AXI_RRESP, rsp;
	logic O_S_AXI_AWREADY, O_S_AXI_WREADY, O_S_AXI_BVALID, O_S_AXI_ARREADY, O_S_AXI_RVALID;
	logic I_WARM_RST_B, I_LINK_CLK, I_STOP_B, I_NEG_DONE, I_EOC_DROP, I_OVERFLOW;
	logic I_LINK_REQ_VALID, I_LINK_REQ_EXT, I_BUS_REQ_VALID;
	logic [2:0] I_NEG_WIDTH, O_ACTIVE_WIDTH;
	logic [63:0] I_LINK_REQ_ADDR, I_BUS_REQ_ADDR, a;
	logic O_LINK_REQ_ACCEPT, O_LINK_REQ_ABORT, O_BUS_REQ_FWD, O_BUS_REQ_EXT, O_BUS_REQ_ABORT;
	logic O_CTL, O_TX_OE, O_SECOND_SPACE_VISIBLE, O_IRQ;
	logic [2:0] cur;
	logic [2:0] codes [5];
	int miscompares, tests_run, cyc, n;

	link_regs link_regs_inst (.*);
	link_peer link_peer_inst (.i_clk(I_CORE_CLK), .o_link_clk(I_LINK_CLK), .o_stop_b(I_STOP_B),
		.o_neg_done(I_NEG_DONE), .o_neg_width(I_NEG_WIDTH));

	initial I_CORE_CLK = 1'b0;
	always #12.5 I_CORE_CLK = ~I_CORE_CLK;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [11:0] ba(input logic [11:0] idx);
		return {idx[9:0], 2'b00};
	endfunction

	function automatic logic [31:0] wexp(input logic [2:0] c);
		return {21'h0, c, 8'h0};
	endfunction

	// accept, abort, forward, extended, bus abort
	function automatic logic [4:0] req_exp(input logic [63:0] ad, input logic en);
		logic hi;
		hi = |ad[63:40];
		return {!hi || en, hi && !en, !hi || en, hi && en, hi && !en};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge I_CORE_CLK);
		I_S_AXI_AWADDR <= ba(idx);
		I_S_AXI_WDATA <= d;
		I_S_AXI_AWVALID <= 1'b1;
		I_S_AXI_WVALID <= 1'b1;
		I_S_AXI_BREADY <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge I_CORE_CLK);
			if (!ad && O_S_AXI_AWREADY === 1'b1) begin
				ad = 1;
				I_S_AXI_AWVALID <= 1'b0;
			end
			if (!wd && O_S_AXI_WREADY === 1'b1) begin
				wd = 1;
				I_S_AXI_WVALID <= 1'b0;
			end
		end
		do @(posedge I_CORE_CLK); while (O_S_AXI_BVALID !== 1'b1);
		rsp = O_S_AXI_BRESP;
		I_S_AXI_BREADY <= 1'b0;
	endtask

	task automatic rd_reg(input logic [11:0] idx);
		@(posedge I_CORE_CLK);
		I_S_AXI_ARADDR <= ba(idx);
		I_S_AXI_ARVALID <= 1'b1;
		I_S_AXI_RREADY <= 1'b1;
		do @(posedge I_CORE_CLK); while (O_S_AXI_ARREADY !== 1'b1);
		I_S_AXI_ARVALID <= 1'b0;
		do @(posedge I_CORE_CLK); while (O_S_AXI_RVALID !== 1'b1);
		rd = O_S_AXI_RDATA;
		rsp = O_S_AXI_RRESP;
		I_S_AXI_RREADY <= 1'b0;
	endtask

	// link and bus request with the same address in the same cycle
	task automatic req(input logic [63:0] ad, input logic en);
		@(posedge I_CORE_CLK);
		I_LINK_REQ_VALID <= 1'b1;
		I_BUS_REQ_VALID <= 1'b1;
		I_LINK_REQ_ADDR <= ad;
		I_BUS_REQ_ADDR <= ad;
		I_LINK_REQ_EXT <= |ad[63:40];
		@(posedge I_CORE_CLK);
		I_LINK_REQ_VALID <= 1'b0;
		I_BUS_REQ_VALID <= 1'b0;
		@(negedge I_CORE_CLK);
		chk({O_LINK_REQ_ACCEPT, O_LINK_REQ_ABORT, O_BUS_REQ_FWD, O_BUS_REQ_EXT, O_BUS_REQ_ABORT}, req_exp(ad, en));
	endtask

	task automatic rand_reqs(input logic en);
		req(64'h0000_00ff_ffff_ffff, en);
		req(64'h0000_0100_0000_0000, en);
		repeat (6) begin
			a = {next_rand(), next_rand()};
			if (a[0])
				a[63:40] = 24'h0;
			req(a, en);
		end
	endtask

	task automatic cold(input logic [1:0] m);
		@(posedge I_CORE_CLK);
		I_RST_B <= 1'b0;
		I_MODE <= m;
		repeat (6) @(posedge I_CORE_CLK);
		I_RST_B <= 1'b1;
		repeat (12) @(posedge I_CORE_CLK);
	endtask

	task automatic warm();
		@(posedge I_CORE_CLK);
		I_WARM_RST_B <= 1'b0;
		repeat (4) @(posedge I_CORE_CLK);
		I_WARM_RST_B <= 1'b1;
		repeat (6) @(negedge I_CORE_CLK);
	endtask

	task automatic pulse_events();
		@(posedge I_CORE_CLK);
		I_EOC_DROP <= 1'b1;
		I_OVERFLOW <= 1'b1;
		@(posedge I_CORE_CLK);
		I_EOC_DROP <= 1'b0;
		I_OVERFLOW <= 1'b0;
	endtask

	// stop low long enough for several link clock rises, then count the control pulse
	task automatic stop_chk(input int exp_cyc, input logic oe_low);
		link_peer_inst.drive_stop(1'b0);
		repeat (30) @(negedge I_CORE_CLK);
		chk(O_TX_OE, !oe_low);
		link_peer_inst.drive_stop(1'b1);
		n = 0;
		repeat (10) if (O_CTL !== 1'b1) @(negedge I_CORE_CLK);
		while (O_CTL === 1'b1 && n < 3000) begin
			n++;
			@(negedge I_CORE_CLK);
		end
		chk(n, exp_cyc);
		repeat (30) @(negedge I_CORE_CLK);
		chk(O_TX_OE, 1);
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// timeout, run is a few thousand cycles
	// ****************************************
	always @(posedge I_CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{I_RST_B, I_S_AXI_AWVALID, I_S_AXI_WVALID, I_S_AXI_BREADY, I_S_AXI_ARVALID, I_S_AXI_RREADY} = '0;
		{I_EOC_DROP, I_OVERFLOW, I_LINK_REQ_VALID, I_LINK_REQ_EXT, I_BUS_REQ_VALID} = '0;
		{I_S_AXI_AWADDR, I_S_AXI_ARADDR, I_S_AXI_WDATA, I_LINK_REQ_ADDR, I_BUS_REQ_ADDR} = '0;
		I_S_AXI_WSTRB = 4'hf;
		I_MODE = link_regs_pkg::GENERIC_SINGLE_MODE;
		I_WARM_RST_B = 1'b1;
		seed = 32'he40cbfac;
		{miscompares, tests_run, cyc} = '0;
		cold(link_regs_pkg::GENERIC_SINGLE_MODE);
		rd_reg(link_regs_pkg::IDX_WIDTH_CFG);
		chk(rd, wexp(link_regs_pkg::WIDTH_4));
		chk(O_ACTIVE_WIDTH, link_regs_pkg::WIDTH_4);
		rd_reg(link_regs_pkg::IDX_LINK_STATE);
		chk(rsp, link_regs_pkg::RESP_OKAY);
		chk(rd, {26'h0, 1'b1, link_regs_pkg::GENERIC_SINGLE_MODE, link_regs_pkg::WIDTH_4});
		$display("test cold load done");
		// unsupported codes must leave the last good width in place
		codes = '{link_regs_pkg::WIDTH_16, link_regs_pkg::WIDTH_8, link_regs_pkg::WIDTH_32,
			link_regs_pkg::WIDTH_4, link_regs_pkg::WIDTH_2};
		cur = link_regs_pkg::WIDTH_4;
		foreach (codes[i]) begin
			wr(link_regs_pkg::IDX_WIDTH_CFG, wexp(codes[i]) | {next_rand() & 32'hffff_f8ff});
			if (codes[i] inside {3'h4, 3'h5, 3'h0})
				cur = codes[i];
			rd_reg(link_regs_pkg::IDX_WIDTH_CFG);
			chk(rd, wexp(cur));
		end
		chk(O_ACTIVE_WIDTH, link_regs_pkg::WIDTH_4);
		rand_reqs(1'b0);
		wr(link_regs_pkg::IDX_LINK1_CTRL, 32'h0000_e000);
		chk(rsp, link_regs_pkg::RESP_OKAY);
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0000_e000);
		rand_reqs(1'b1);
		stop_chk(link_regs_pkg::CTL_EXT_CYC, 1'b1);
		$display("test generic width, requests and stop done");
		rd_reg(link_regs_pkg::IDX_IRQ_STATUS);
		chk(rd, 32'h4);
		wr(link_regs_pkg::IDX_IRQ_MASK, 32'hf);
		warm();
		chk(O_IRQ, 0);
		wr(link_regs_pkg::IDX_IRQ_MASK, 32'h0);
		@(negedge I_CORE_CLK);
		chk(O_IRQ, 1);
		chk(O_ACTIVE_WIDTH, link_regs_pkg::WIDTH_2);
		rd_reg(link_regs_pkg::IDX_IRQ_STATUS);
		chk(rd, 32'h8);
		repeat (2) @(negedge I_CORE_CLK);
		chk(O_IRQ, 0);
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0000_6000);
		wr(link_regs_pkg::IDX_LINK1_CTRL, 32'h0);
		stop_chk(link_regs_pkg::CTL_BASE_CYC, 1'b0);
		$display("test warm reset and interrupt done");
		cold(link_regs_pkg::SINGLE_BRIDGE_MODE);
		chk(O_SECOND_SPACE_VISIBLE, 0);
		wr(link_regs_pkg::IDX_WIDTH_CFG, wexp(link_regs_pkg::WIDTH_2));
		rd_reg(link_regs_pkg::IDX_WIDTH_CFG);
		chk(rd, wexp(link_regs_pkg::WIDTH_8));
		pulse_events();
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0000_6000);
		wr(link_regs_pkg::IDX_LINK1_CTRL, 32'h0);
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0000_6000);
		wr(link_regs_pkg::IDX_LINK1_CTRL, 32'h0000_4000);
		warm();
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0000_2000);
		wr(link_regs_pkg::IDX_LINK1_CTRL, 32'h0000_2000);
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0);
		fork
			wr(link_regs_pkg::IDX_LINK1_CTRL, 32'h0000_4000);
			begin
				// drop lands in the cycle the clearing write commits
				repeat (2) @(posedge I_CORE_CLK);
				I_EOC_DROP <= 1'b1;
				@(posedge I_CORE_CLK);
				I_EOC_DROP <= 1'b0;
			end
		join
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0000_4000);
		req(64'hffff_0000_0000_0000, 1'b0);
		$display("test single bridge flags done");
		cold(link_regs_pkg::DUAL_BRIDGE_MODE);
		chk(O_SECOND_SPACE_VISIBLE, 1);
		pulse_events();
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0);
		rd_reg(12'h0ff);
		chk({rsp, rd[29:0]}, {link_regs_pkg::RESP_SLVERR, 30'h0});
		wr(12'h0ff, 32'hffff_ffff);
		chk(rsp, link_regs_pkg::RESP_SLVERR);
		cold(link_regs_pkg::GENERIC_DUAL_MODE);
		chk(O_SECOND_SPACE_VISIBLE, 1);
		wr(link_regs_pkg::IDX_LINK1_CTRL, 32'h0000_8000);
		rd_reg(link_regs_pkg::IDX_LINK1_CTRL);
		chk(rd, 32'h0);
		req(64'h0000_0100_0000_0000, 1'b1);
		$display("test dual mode and unmapped access done");
		wrap_up();
	end
endmodule
